//--- rtl/chan_irq_pkg.sv
// Package for the channel interrupt status and mask block.
// Assumes a 32-bit register port with word offsets given as byte addresses.
package chan_irq_pkg;

  localparam int NUM_CHAN = 8;

  // ==========================================================
  // Register offsets (byte addresses)
  // ==========================================================
  localparam logic [7:0] OFS_TX_RAW_PENDING     = 8'h00;
  localparam logic [7:0] OFS_TX_MASKED_PENDING  = 8'h04;
  localparam logic [7:0] OFS_TX_MASK_SET        = 8'h08;
  localparam logic [7:0] OFS_TX_MASK_CLEAR      = 8'h0C;
  localparam logic [7:0] OFS_COMBINED_VECTOR    = 8'h10;
  localparam logic [7:0] OFS_END_OF_INTERRUPT   = 8'h14;
  localparam logic [7:0] OFS_RX_RAW_PENDING     = 8'h18;
  localparam logic [7:0] OFS_RX_MASKED_PENDING  = 8'h1C;
  localparam logic [7:0] OFS_RX_MASK_SET        = 8'h20;
  localparam logic [7:0] OFS_RX_MASK_CLEAR      = 8'h24;
  localparam logic [7:0] OFS_EVENT_STATUS       = 8'h28;
  localparam logic [7:0] OFS_EVENT_MASK         = 8'h2C;

  // ==========================================================
  // Combined input vector layout
  // ==========================================================
  localparam int BIT_STATISTICS  = 27;
  localparam int BIT_HOST_ERROR  = 26;
  localparam int BIT_LINK_CHANGE = 25;
  localparam int BIT_MGMT_USER   = 24;
  localparam int LSB_TX_FIELD    = 16;
  localparam int LSB_RX_THRESH   = 8;
  localparam int LSB_RX_FIELD    = 0;

  // ==========================================================
  // Completion codes and event status layout
  // ==========================================================
  typedef enum logic [1:0] {
    CODE_RX_THRESH = 2'h0,
    CODE_RX_PULSE  = 2'h1,
    CODE_TX_PULSE  = 2'h2,
    CODE_MISC      = 2'h3
  } completion_code_e;

  localparam int GROUP_COUNT = 4;

  localparam logic [7:0]  CHAN_RESET  = 8'h00;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
  localparam logic [3:0]  GROUP_ZERO  = 4'h0;

endpackage

//--- rtl/mac_channel_interrupt_status.sv
// Channel interrupt status, masks, combined vector and completion codes.
// Assumes pending inputs are synchronous levels from the channel logic and
// a single-cycle register port with read data one cycle after the strobe.
`timescale 1ns/100ps

module mac_channel_interrupt_status
  import chan_irq_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  input  wire logic [7:0]  tx_chan_pending_bit,
  input  wire logic [7:0]  rx_chan_pending_bit,
  input  wire logic [7:0]  rx_thresh_pending,
  input  wire logic        statistics_pending,
  input  wire logic        host_error_pending,
  input  wire logic        link_change_pending,
  input  wire logic        mgmt_user_pending,
  output logic             rx_threshold_group,
  output logic             rx_pulse_group,
  output logic             tx_pulse_group,
  output logic             misc_group,
  output logic             irq
);

  // ==========================================================
  // Masks
  // ==========================================================
  logic [7:0] tx_chan_enable_bit;
  logic [7:0] rx_chan_enable_bit;
  logic       wr_tx_set;
  logic       wr_tx_clr;
  logic       wr_rx_set;
  logic       wr_rx_clr;
  logic       wr_completion;
  logic       wr_evt_status;
  logic       wr_evt_mask;

  assign wr_tx_set     = reg_write && (reg_addr == OFS_TX_MASK_SET);
  assign wr_tx_clr     = reg_write && (reg_addr == OFS_TX_MASK_CLEAR);
  assign wr_rx_set     = reg_write && (reg_addr == OFS_RX_MASK_SET);
  assign wr_rx_clr     = reg_write && (reg_addr == OFS_RX_MASK_CLEAR);
  assign wr_completion = reg_write && (reg_addr == OFS_END_OF_INTERRUPT);
  assign wr_evt_status = reg_write && (reg_addr == OFS_EVENT_STATUS);
  assign wr_evt_mask   = reg_write && (reg_addr == OFS_EVENT_MASK);

  // One bit per channel; set and clear registers are separate addresses so
  // a single write never both sets and clears the same bit.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_mask
      always_ff @(posedge core_clk) begin
        if (reset) begin
          tx_chan_enable_bit[gi] <= 1'b0;
          rx_chan_enable_bit[gi] <= 1'b0;
        end else begin
          if (wr_tx_set && reg_wdata[gi]) begin
            tx_chan_enable_bit[gi] <= 1'b1;
          end else if (wr_tx_clr && reg_wdata[gi]) begin
            tx_chan_enable_bit[gi] <= 1'b0;
          end
          if (wr_rx_set && reg_wdata[gi]) begin
            rx_chan_enable_bit[gi] <= 1'b1;
          end else if (wr_rx_clr && reg_wdata[gi]) begin
            rx_chan_enable_bit[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Status views
  // ==========================================================
  logic [7:0]  tx_masked;
  logic [7:0]  rx_masked;
  logic [31:0] combined_input_vector;

  assign tx_masked = tx_chan_pending_bit & tx_chan_enable_bit;
  assign rx_masked = rx_chan_pending_bit & rx_chan_enable_bit;

  always_comb begin
    combined_input_vector                                = WORD_ZERO;
    combined_input_vector[BIT_STATISTICS]                = statistics_pending;
    combined_input_vector[BIT_HOST_ERROR]                = host_error_pending;
    combined_input_vector[BIT_LINK_CHANGE]               = link_change_pending;
    combined_input_vector[BIT_MGMT_USER]                 = mgmt_user_pending;
    combined_input_vector[LSB_TX_FIELD +: NUM_CHAN]      = tx_chan_pending_bit;
    combined_input_vector[LSB_RX_THRESH +: NUM_CHAN]     = rx_thresh_pending;
    combined_input_vector[LSB_RX_FIELD +: NUM_CHAN]      = rx_chan_pending_bit;
  end

  // ==========================================================
  // Group pacing by completion codes
  // ==========================================================
  // A group line drops for one cycle on its completion code so that an
  // edge-sensitive consumer sees a fresh edge when work still remains.
  logic [3:0] group_active;
  logic [3:0] group_hold;
  logic [1:0] end_of_interrupt_vector;

  assign group_active[CODE_RX_THRESH] = |rx_thresh_pending;
  assign group_active[CODE_RX_PULSE]  = |rx_masked;
  assign group_active[CODE_TX_PULSE]  = |tx_masked;
  assign group_active[CODE_MISC]      = statistics_pending | host_error_pending |
                                        link_change_pending | mgmt_user_pending;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      group_hold              <= GROUP_ZERO;
      end_of_interrupt_vector <= CODE_RX_THRESH;
    end else begin
      group_hold <= GROUP_ZERO;
      if (wr_completion) begin
        end_of_interrupt_vector <= reg_wdata[1:0];
        group_hold[reg_wdata[1:0]] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_threshold_group <= 1'b0;
      rx_pulse_group     <= 1'b0;
      tx_pulse_group     <= 1'b0;
      misc_group         <= 1'b0;
    end else begin
      // Re-evaluated every cycle, so a held group returns if still pending
      rx_threshold_group <= group_active[CODE_RX_THRESH] && !group_hold[CODE_RX_THRESH];
      rx_pulse_group     <= group_active[CODE_RX_PULSE]  && !group_hold[CODE_RX_PULSE];
      tx_pulse_group     <= group_active[CODE_TX_PULSE]  && !group_hold[CODE_TX_PULSE];
      misc_group         <= group_active[CODE_MISC]      && !group_hold[CODE_MISC];
    end
  end

  // ==========================================================
  // Sticky event status, mask and interrupt line
  // ==========================================================
  logic [3:0] event_status;
  logic [3:0] event_mask;
  logic [3:0] group_prev;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      group_prev <= GROUP_ZERO;
    end else begin
      group_prev <= group_active;
    end
  end

  // Rising edge of a group sets its bit; set wins over a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      event_status <= GROUP_ZERO;
    end else if (wr_evt_status) begin
      event_status <= (event_status & ~reg_wdata[3:0]) | (group_active & ~group_prev);
    end else begin
      event_status <= event_status | (group_active & ~group_prev);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      event_mask <= GROUP_ZERO;
    end else if (wr_evt_mask) begin
      event_mask <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(event_status & event_mask);
    end
  end

  // ==========================================================
  // Read port
  // ==========================================================
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = WORD_ZERO;
    case (reg_addr)
      OFS_TX_RAW_PENDING:    next_rdata[7:0] = tx_chan_pending_bit;
      OFS_TX_MASKED_PENDING: next_rdata[7:0] = tx_masked;
      OFS_TX_MASK_SET:       next_rdata[7:0] = tx_chan_enable_bit;
      OFS_TX_MASK_CLEAR:     next_rdata[7:0] = tx_chan_enable_bit;
      OFS_COMBINED_VECTOR:   next_rdata      = combined_input_vector;
      OFS_END_OF_INTERRUPT:  next_rdata[1:0] = end_of_interrupt_vector;
      OFS_RX_RAW_PENDING:    next_rdata[7:0] = rx_chan_pending_bit;
      OFS_RX_MASKED_PENDING: next_rdata[7:0] = rx_masked;
      OFS_RX_MASK_SET:       next_rdata[7:0] = rx_chan_enable_bit;
      OFS_RX_MASK_CLEAR:     next_rdata[7:0] = rx_chan_enable_bit;
      OFS_EVENT_STATUS:      next_rdata[3:0] = event_status;
      OFS_EVENT_MASK:        next_rdata[3:0] = event_mask;
      default:               next_rdata      = WORD_ZERO;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= WORD_ZERO;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= WORD_ZERO;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  AST_TX_RAW: assert property (@(posedge core_clk) disable iff (reset)
    reg_read && reg_addr == OFS_TX_RAW_PENDING |=> reg_rdata == {24'h000000, $past(tx_chan_pending_bit)})
    else $error("tx raw read wrong");
  AST_TX_MASKED: assert property (@(posedge core_clk) disable iff (reset)
    reg_read && reg_addr == OFS_TX_MASKED_PENDING
      |=> reg_rdata == {24'h000000, $past(tx_chan_pending_bit & tx_chan_enable_bit)})
    else $error("tx masked read wrong");
  AST_TX_SET: assert property (@(posedge core_clk) disable iff (reset)
    wr_tx_set |=> (tx_chan_enable_bit & $past(reg_wdata[7:0])) == $past(reg_wdata[7:0]))
    else $error("tx mask set failed");
  AST_TX_CLR: assert property (@(posedge core_clk) disable iff (reset)
    wr_tx_clr |=> (tx_chan_enable_bit & $past(reg_wdata[7:0])) == 8'h00)
    else $error("tx mask clear failed");
  AST_RX_RAW: assert property (@(posedge core_clk) disable iff (reset)
    reg_read && reg_addr == OFS_RX_RAW_PENDING |=> reg_rdata == {24'h000000, $past(rx_chan_pending_bit)})
    else $error("rx raw read wrong");
  AST_VEC_MISC: assert property (@(posedge core_clk) disable iff (reset)
    reg_read && reg_addr == OFS_COMBINED_VECTOR
      |=> reg_rdata[31:24] == {4'h0, $past(statistics_pending), $past(host_error_pending),
                               $past(link_change_pending), $past(mgmt_user_pending)})
    else $error("vector upper bits wrong");
  AST_VEC_CHAN: assert property (@(posedge core_clk) disable iff (reset)
    reg_read && reg_addr == OFS_COMBINED_VECTOR
      |=> reg_rdata[23:0] == {$past(tx_chan_pending_bit), $past(rx_thresh_pending), $past(rx_chan_pending_bit)})
    else $error("vector channel fields wrong");
  AST_CODE_DROP: assert property (@(posedge core_clk) disable iff (reset)
    wr_completion && reg_wdata[1:0] == 2'h2 |=> ##1 !tx_pulse_group)
    else $error("tx group did not drop on completion");
  AST_REASSERT: assert property (@(posedge core_clk) disable iff (reset)
    wr_completion && reg_wdata[1:0] == 2'h1 ##1 ((|rx_masked) && !wr_completion)
      ##1 (|rx_masked) |=> rx_pulse_group)
    else $error("rx pulse group did not return");
  AST_RX_MASK: assert property (@(posedge core_clk) disable iff (reset)
    wr_rx_clr && reg_wdata[0] |=> !rx_chan_enable_bit[0])
    else $error("rx mask clear failed");
  AST_IRQ: assert property (@(posedge core_clk) disable iff (reset)
    (|(event_status & event_mask)) |=> irq)
    else $error("irq not raised");

  // ==========================================================
  // Further checks: vector fields, masks, codes, events
  // ==========================================================
  // Each read view is compared with its sources as they stood at the strobe
  AST_RX_MASKED: assert property (@(posedge core_clk) disable iff (reset)
    reg_read && reg_addr == OFS_RX_MASKED_PENDING
      |=> reg_rdata == {24'h000000, $past(rx_chan_pending_bit & rx_chan_enable_bit)})
    else $error("rx masked read wrong");

  AST_VEC_LINK: assert property (@(posedge core_clk) disable iff (reset)
    reg_read && reg_addr == OFS_COMBINED_VECTOR
      |=> reg_rdata[BIT_LINK_CHANGE] == $past(link_change_pending)
          && reg_rdata[BIT_MGMT_USER] == $past(mgmt_user_pending))
    else $error("vector management bits wrong");

  AST_VEC_THRESH: assert property (@(posedge core_clk) disable iff (reset)
    reg_read && reg_addr == OFS_COMBINED_VECTOR
      |=> reg_rdata[LSB_RX_THRESH +: NUM_CHAN] == $past(rx_thresh_pending))
    else $error("vector threshold field wrong");

  AST_VEC_RX: assert property (@(posedge core_clk) disable iff (reset)
    reg_read && reg_addr == OFS_COMBINED_VECTOR
      |=> reg_rdata[LSB_RX_FIELD +: NUM_CHAN] == $past(rx_chan_pending_bit))
    else $error("vector receive field wrong");

  // Set and clear touch only the bits written as one; all others must hold
  AST_TX_SET_KEEP: assert property (@(posedge core_clk) disable iff (reset)
    wr_tx_set |=> (tx_chan_enable_bit & ~$past(reg_wdata[7:0]))
                  == ($past(tx_chan_enable_bit) & ~$past(reg_wdata[7:0])))
    else $error("tx mask set touched other bits");

  AST_TX_CLR_KEEP: assert property (@(posedge core_clk) disable iff (reset)
    wr_tx_clr |=> (tx_chan_enable_bit & ~$past(reg_wdata[7:0]))
                  == ($past(tx_chan_enable_bit) & ~$past(reg_wdata[7:0])))
    else $error("tx mask clear touched other bits");

  AST_RX_SET: assert property (@(posedge core_clk) disable iff (reset)
    wr_rx_set |=> (rx_chan_enable_bit & $past(reg_wdata[7:0])) == $past(reg_wdata[7:0]))
    else $error("rx mask set failed");

  AST_RX_CLR: assert property (@(posedge core_clk) disable iff (reset)
    wr_rx_clr |=> (rx_chan_enable_bit & $past(reg_wdata[7:0])) == 8'h00)
    else $error("rx mask clear failed on some bit");

  AST_RX_KEEP: assert property (@(posedge core_clk) disable iff (reset)
    wr_rx_set || wr_rx_clr |=> (rx_chan_enable_bit & ~$past(reg_wdata[7:0]))
                               == ($past(rx_chan_enable_bit) & ~$past(reg_wdata[7:0])))
    else $error("rx mask write touched other bits");

  // No reset guard here, since the guard would hide the very cycle checked
  AST_MASK_RESET: assert property (@(posedge core_clk)
    $past(reset) |-> tx_chan_enable_bit == CHAN_RESET && rx_chan_enable_bit == CHAN_RESET)
    else $error("masks not cleared by reset");

  // Each code drops only its own group, two edges after the write
  AST_CODE_THRESH: assert property (@(posedge core_clk) disable iff (reset)
    wr_completion && reg_wdata[1:0] == CODE_RX_THRESH |=> ##1 !rx_threshold_group)
    else $error("threshold group did not drop on completion");

  AST_CODE_RX: assert property (@(posedge core_clk) disable iff (reset)
    wr_completion && reg_wdata[1:0] == CODE_RX_PULSE |=> ##1 !rx_pulse_group)
    else $error("rx group did not drop on completion");

  AST_CODE_MISC: assert property (@(posedge core_clk) disable iff (reset)
    wr_completion && reg_wdata[1:0] == CODE_MISC |=> ##1 !misc_group)
    else $error("misc group did not drop on completion");

  AST_CODE_KEEP: assert property (@(posedge core_clk) disable iff (reset)
    wr_completion |=> end_of_interrupt_vector == $past(reg_wdata[1:0]))
    else $error("completion code not stored");

  // Outside a hold a group simply follows its condition one edge later
  AST_TX_RETURN: assert property (@(posedge core_clk) disable iff (reset)
    !group_hold[CODE_TX_PULSE] && group_active[CODE_TX_PULSE] |=> tx_pulse_group)
    else $error("tx group missing while pending");

  AST_MISC_RETURN: assert property (@(posedge core_clk) disable iff (reset)
    !group_hold[CODE_MISC] && group_active[CODE_MISC] |=> misc_group)
    else $error("misc group missing while pending");

  AST_THRESH_IDLE: assert property (@(posedge core_clk) disable iff (reset)
    !group_active[CODE_RX_THRESH] |=> !rx_threshold_group)
    else $error("threshold group high while idle");

  // Set wins: a new rising condition is never lost to a same-cycle clear
  AST_EVT_SET: assert property (@(posedge core_clk) disable iff (reset)
    (|(group_active & ~group_prev))
      |=> (event_status & $past(group_active & ~group_prev)) == $past(group_active & ~group_prev))
    else $error("event status bit not set");

  AST_EVT_CLR: assert property (@(posedge core_clk) disable iff (reset)
    wr_evt_status
      |=> (event_status & $past(reg_wdata[3:0] & ~(group_active & ~group_prev))) == GROUP_ZERO)
    else $error("event status bit not cleared");

  AST_IRQ_LOW: assert property (@(posedge core_clk) disable iff (reset)
    !(|(event_status & event_mask)) |=> !irq)
    else $error("irq high with nothing unmasked");

  // A stale word on the read bus would look like a fresh read
  AST_RDATA_IDLE: assert property (@(posedge core_clk) disable iff (reset)
    !reg_read |=> reg_rdata == WORD_ZERO)
    else $error("read data left standing");

  COV_TX_MASK: cover property (@(posedge core_clk) disable iff (reset) wr_tx_set ##1 tx_pulse_group);
  COV_CODE:    cover property (@(posedge core_clk) disable iff (reset) wr_completion ##2 rx_pulse_group);
  COV_IRQ:     cover property (@(posedge core_clk) disable iff (reset) $rose(irq));
  COV_VEC:     cover property (@(posedge core_clk) disable iff (reset)
    reg_read && reg_addr == OFS_COMBINED_VECTOR && statistics_pending);

endmodule

//--- test/testbench.sv
// Self-checking bench for the channel interrupt status and mask block.
// Assumes the block's own assertions sit in its file; drives every port directly.
`timescale 1ns/100ps

module testbench
  import chan_irq_pkg::*;
;
  // ==========================================================
  // Signals and clock
  // ==========================================================
  typedef struct packed {
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic [7:0]  thr;
    logic [3:0]  misc;
    logic [31:0] vec;
  } row_s;

  logic        core_clk;
  logic        reset;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [31:0] reg_rdata;
  logic [7:0]  tx_pend;
  logic [7:0]  rx_pend;
  logic [7:0]  thr_pend;
  logic [3:0]  misc_pend;
  logic [3:0]  groups;
  logic        irq;
  logic [31:0] seen;
  logic [3:0]  s1;
  logic [3:0]  s2;
  int          errors;
  int          checks_done;

  // Misc order: statistics, host error, link change, management user
  row_s rows [5] = '{
    '{8'h01, 8'h80, 8'h00, 4'h8, 32'h0801_0080},
    '{8'h80, 8'h01, 8'h01, 4'h4, 32'h0480_0101},
    '{8'h00, 8'h00, 8'h80, 4'h2, 32'h0200_8000},
    '{8'hFF, 8'hFF, 8'hFF, 4'h1, 32'h01FF_FFFF},
    '{8'hA5, 8'h5A, 8'h3C, 4'hF, 32'h0FA5_3C5A}};

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  mac_channel_interrupt_status mac_channel_interrupt_status_inst (
    .core_clk            (core_clk),
    .reset               (reset),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_write           (reg_write),
    .reg_read            (reg_read),
    .reg_rdata           (reg_rdata),
    .tx_chan_pending_bit (tx_pend),
    .rx_chan_pending_bit (rx_pend),
    .rx_thresh_pending   (thr_pend),
    .statistics_pending  (misc_pend[3]),
    .host_error_pending  (misc_pend[2]),
    .link_change_pending (misc_pend[1]),
    .mgmt_user_pending   (misc_pend[0]),
    .rx_threshold_group  (groups[0]),
    .rx_pulse_group      (groups[1]),
    .tx_pulse_group      (groups[2]),
    .misc_group          (groups[3]),
    .irq                 (irq)
  );

  // ==========================================================
  // Bus and check tasks
  // ==========================================================
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; returns just after the edge that took the write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    // Step off the edge so a following write never sets the strobe in the same step
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Watchdog: the sequence needs well under 1000 cycles
  // ==========================================================
  initial begin
    #(40 * 4000);
    errors++;
    conclude();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    errors = 0;
    checks_done = 0;
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    tx_pend = 8'h00;
    rx_pend = 8'h00;
    thr_pend = 8'h00;
    misc_pend = 4'h0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(OFS_TX_MASK_SET, 32'h0);
    rd(OFS_RX_MASK_SET, 32'h0);
    check({31'h0, irq}, 32'h0);

    // Event capture, masking and write-one clear
    misc_pend <= 4'h8;
    repeat (3) @(posedge core_clk);
    rd(OFS_EVENT_STATUS, 32'h8);
    check({31'h0, irq}, 32'h0);
    wr(OFS_EVENT_MASK, 32'h8);
    repeat (2) @(posedge core_clk);
    #1 check({31'h0, irq}, 32'h1);
    wr(OFS_EVENT_STATUS, 32'h8);
    repeat (2) @(posedge core_clk);
    #1 check({31'h0, irq}, 32'h0);
    rd(OFS_EVENT_STATUS, 32'h0);
    // The misc condition must fall before a new source can make a fresh edge
    misc_pend <= 4'h0;
    @(posedge core_clk);
    misc_pend <= 4'h4;
    repeat (3) @(posedge core_clk);
    #1 check({31'h0, irq}, 32'h1);

    // Ordinary cases: raw views and combined vector
    foreach (rows[i]) begin
      tx_pend <= rows[i].tx;
      rx_pend <= rows[i].rx;
      thr_pend <= rows[i].thr;
      misc_pend <= rows[i].misc;
      @(posedge core_clk);
      rd(OFS_TX_RAW_PENDING, {24'h0, rows[i].tx});
      rd(OFS_RX_RAW_PENDING, {24'h0, rows[i].rx});
      rd(OFS_COMBINED_VECTOR, rows[i].vec);
    end

    // Masks: all pending, so masked views expose the masks
    tx_pend <= 8'hFF;
    rx_pend <= 8'hFF;
    @(posedge core_clk);
    rd(OFS_TX_MASKED_PENDING, 32'h0);
    wr(OFS_TX_MASK_SET, 32'hFFFF_FF81);
    rd(OFS_TX_MASKED_PENDING, 32'h81);
    wr(OFS_TX_MASK_SET, 32'h0);
    wr(OFS_TX_MASK_CLEAR, 32'h01);
    rd(OFS_TX_MASKED_PENDING, 32'h80);
    wr(OFS_TX_MASK_CLEAR, 32'h0);
    rd(OFS_TX_MASK_SET, 32'h80);
    rd(OFS_RX_MASKED_PENDING, 32'h0);
    wr(OFS_RX_MASK_SET, 32'h42);
    wr(OFS_RX_MASK_SET, 32'h0);
    rd(OFS_RX_MASKED_PENDING, 32'h42);
    wr(OFS_RX_MASK_CLEAR, 32'h02);
    rd(OFS_RX_MASKED_PENDING, 32'h40);
    tx_pend <= 8'h01;
    @(posedge core_clk);
    rd(OFS_TX_MASKED_PENDING, 32'h0);

    // Refused accesses: unmapped and read-only places
    rd(8'h30, 32'h0);
    wr(8'h30, 32'hFFFF_FFFF);
    wr(OFS_TX_RAW_PENDING, 32'hFFFF_FFFF);
    rd(OFS_TX_RAW_PENDING, 32'h01);
    wr(OFS_COMBINED_VECTOR, 32'h0);
    rd(OFS_COMBINED_VECTOR, 32'h0F01_3CFF);
    @(posedge core_clk);
    #1 check(reg_rdata, 32'h0);

    // Completion codes: each drops only its own group for one cycle
    tx_pend <= 8'h80;
    wr(OFS_TX_MASK_SET, 32'hFF);
    wr(OFS_RX_MASK_SET, 32'hFF);
    @(posedge core_clk);
    #1 check({28'h0, groups}, 32'hF);
    for (int k = 0; k < GROUP_COUNT; k++) begin
      @(posedge core_clk);
      wr(OFS_END_OF_INTERRUPT, k);
      @(posedge core_clk);
      #1 s1 = groups;
      @(posedge core_clk);
      #1 s2 = groups;
      @(posedge core_clk);
      #1 check({24'h0, s1, s2}, {24'h0, 4'hF & ~(4'h1 << k), 4'hF});
      check({28'h0, groups}, 32'hF);
      rd(OFS_END_OF_INTERRUPT, k);
    end

    // Second reset in mid-run clears the masks again
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(OFS_TX_MASK_SET, 32'h0);
    rd(OFS_RX_MASKED_PENDING, 32'h0);
    conclude();
  end
endmodule
